// File: sel_defs.svh
`ifndef SEL_DEFS_SVH
`define SEL_DEFS_SVH
// eeprom geometry
`define SEL_AW          6
`define SEL_DW          16
// strap value that selects the fixed defaults
`define SEL_STRAP_DFLT  3'h7
// station address words
`define SEL_SA_BASE     6'h20
`define SEL_SA_WORDS    2'h3
// serial opcodes (start bit included): read, write, write-enable
`define SEL_OP_READ     3'h6
`define SEL_OP_WRITE    3'h5
`define SEL_OP_EWEN     3'h4
`define SEL_EWEN_ADDR   6'h30
// serial frame: 3 command bits + 6 address + 16 data
`define SEL_FRAME_BITS  5'h19
`define SEL_CMD_BITS    5'h09
// timing
`define SEL_SK_NS       1000
`define SEL_CLK_NS      10
`define SEL_SK_HALF     ((`SEL_SK_NS / 2) / `SEL_CLK_NS)
`define SEL_WR_BUSY_NS  10000000
`define SEL_WR_BUSY_CYC (`SEL_WR_BUSY_NS / `SEL_CLK_NS)
// default register values
`define SEL_CFG_DFLT    16'h0000
`define SEL_BASE_DFLT   16'h0000
`define SEL_SA_DFLT     16'h0000
`endif

// File: sel_eeprom_model.sv
`timescale 1ns/1ps
module sel_eeprom_model (
  // serial pins
  input  wire logic ee_cs,
  input  wire logic ee_sk,
  input  wire logic ee_di,
  output logic      ee_do
);
  logic [15:0] mem [64];  // whole words, word addresses only
  logic [24:0] sh;
  logic [8:0]  cmd;
  logic        wen;
  int          cnt;

  initial begin
    ee_do = 1'b0;
    wen   = 1'b0;
    cnt   = 0;
  end

  always @(posedge ee_cs) begin
    cnt = 0;
  end

  always @(posedge ee_sk) begin
    if (ee_cs) begin
      sh  = {sh[23:0], ee_di};
      cnt = cnt + 1;
      if (cnt == 9) begin
        cmd = sh[8:0];
      end
    end
  end

  // read data leaves msb first after start, opcode and address
  always @(negedge ee_sk) begin
    if (ee_cs && cnt >= 9 && cnt < 25 && cmd[8:6] == 3'h6) begin
      ee_do <= mem[cmd[5:0]][24-cnt];
    end
  end

  // a write lands only after write-enable, and only as a whole word
  always @(negedge ee_cs) begin
    if (cnt == 9 && cmd[8:6] == 3'h4 && cmd[5:4] == 2'h3) begin
      wen = 1'b1;
    end
    if (cnt == 25 && cmd[8:6] == 3'h5 && wen) begin
      mem[cmd[5:0]] = sh[15:0];
    end
    // line released and unpulled: never leave the last bit standing
    ee_do <= ~ee_do;
  end
endmodule : sel_eeprom_model

// File: sel_loader.sv
// Contract
// - reset loads setup, base, station address
// - setup at strap*4, base at plus one
// - station address always words 20h-22h
// - strap 7: fetch loads station address only, defaults kept; store still writes setup, base
// - eeprom is 64 whole 16-bit words
// - select 0 fetch loads setup/base/address
// - select 0 store writes setup, base
// - control bits never saved or loaded
// - select 1 fetch reads pointer word
// - select 1 store writes scratch word
// - triggers self-clear when access finishes
// - both triggers read high while busy
// - other bits locked while busy
// - no eeprom: no access, defaults kept
`timescale 1ns/1ps
`include "sel_defs.svh"
module sel_loader #(
  parameter int WR_BUSY_CYC = `SEL_WR_BUSY_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // board pins
  input  wire logic [2:0]           eeprom_offset_straps,
  input  wire logic                 eeprom_present_pin,
  // host control
  input  wire logic                 ctrl_we,
  input  wire sel_pkg::sel_ctrl_t   ctrl_wdata,
  input  wire logic                 reg_we,
  input  wire logic [2:0]           reg_wsel,
  input  wire logic [15:0]          reg_wdata,
  output sel_pkg::sel_ctrl_t        control_reg,
  output logic                      busy,
  output logic [15:0]               cfg_reg,
  output logic [15:0]               base_reg,
  output logic [47:0]               station_addr,
  output logic [5:0]                pointer_reg,
  output logic [15:0]               scratch_reg,
  // serial eeprom
  output logic                      ee_cs,
  output logic                      ee_sk,
  output logic                      ee_di,
  input  wire logic                 ee_do
);
  import sel_pkg::*;

  localparam int HALF = (`SEL_SK_HALF < 1) ? 1 : `SEL_SK_HALF;

  // reg_wsel codes: 0 cfg, 1 base, 2..4 station address, 5 pointer, 6 scratch
  sel_state_t       st_q;
  logic [1:0]       strap_s1_q, strap_s2_q;
  logic [2:0]       strap_hi_q, strap_lo_q;
  logic [2:0]       pres_q;
  logic [1:0]       do_q;       // eeprom answer, two flops from the pin
  logic             boot_q;
  logic [2:0]       job_q;      // word step in current sequence
  logic             wr_q;       // current job writes
  logic             ewen_q;     // write-enable frame pending
  logic [24:0]      sh_q;
  logic [4:0]       bit_q;
  logic [4:0]       nbits_q;
  logic [15:0]      rd_q;
  logic [31:0]      tmr_q;
  logic             ph_q;
  logic [5:0]       addr_q;

  function automatic logic [5:0] setup_addr(input logic [2:0] s, input logic b);
    setup_addr = {1'b0, s, 1'b0, b};
  endfunction : setup_addr

  // straps pass two flops, presence pin three
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_hi_q <= 3'h0;
      strap_lo_q <= 3'h0;
      pres_q     <= 3'h0;
      do_q       <= 2'h0;
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
    end else begin
      strap_hi_q <= eeprom_offset_straps;
      strap_lo_q <= strap_hi_q;
      pres_q     <= {pres_q[1:0], eeprom_present_pin};
      do_q       <= {do_q[0], ee_do};
      strap_s1_q <= {strap_s1_q[0], 1'b1};
      strap_s2_q <= strap_s1_q;
    end
  end

  wire       present = pres_q[2];
  wire [2:0] strap   = strap_lo_q;
  wire       settled = strap_s2_q[1];
  wire       dflt    = (strap == `SEL_STRAP_DFLT);
  // sequence: job 0 setup, 1 base, 2..4 station address; select=1 uses one job
  wire       skip_cb = dflt & control_reg.fetch & ~control_reg.select;
  wire [2:0] last_job = control_reg.select ? 3'h0 : (wr_q ? 3'h1 : 3'h4);

  function automatic logic [5:0] job_addr(input logic [2:0] j);
    if (control_reg.select) job_addr = pointer_reg;
    else if (j < 3'h2)      job_addr = setup_addr(strap, j[0]);
    else                    job_addr = `SEL_SA_BASE + {3'h0, j} - 6'h2;
  endfunction : job_addr

  function automatic logic [15:0] job_wdata(input logic [2:0] j);
    if (control_reg.select) job_wdata = scratch_reg;
    else if (j[0])          job_wdata = base_reg;
    else                    job_wdata = cfg_reg;
  endfunction : job_wdata

  // sequencer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= SEL_IDLE;
      boot_q  <= 1'b1;
      job_q   <= 3'h0;
      wr_q    <= 1'b0;
      ewen_q  <= 1'b0;
      sh_q    <= 25'h0;
      bit_q   <= 5'h0;
      nbits_q <= 5'h0;
      rd_q    <= 16'h0;
      tmr_q   <= 32'h0;
      ph_q    <= 1'b0;
      addr_q  <= 6'h0;
      ee_cs   <= 1'b0;
      ee_sk   <= 1'b0;
      ee_di   <= 1'b0;
    end else begin
      unique case (st_q)
        SEL_IDLE: begin
          if (boot_q && settled) begin
            boot_q <= 1'b0;
            if (present) begin
              wr_q  <= 1'b0;
              job_q <= dflt ? 3'h2 : 3'h0;
              st_q  <= SEL_PLAN;
            end
          end else if (!boot_q && present && (control_reg.fetch || control_reg.store)) begin
            wr_q   <= control_reg.store & ~control_reg.fetch;
            ewen_q <= control_reg.store & ~control_reg.fetch;
            job_q  <= skip_cb ? 3'h2 : 3'h0;
            st_q   <= SEL_PLAN;
          end
        end
        SEL_PLAN: begin
          // one frame: cs high, start+op, 6-bit address, then 16 data bits for read and write (write-enable ends after the address)
          addr_q <= job_addr(job_q);
          if (ewen_q) begin
            sh_q    <= {`SEL_OP_EWEN, `SEL_EWEN_ADDR, 16'h0};
            nbits_q <= `SEL_CMD_BITS;
          end else if (wr_q) begin
            sh_q    <= {`SEL_OP_WRITE, job_addr(job_q), job_wdata(job_q)};
            nbits_q <= `SEL_FRAME_BITS;
          end else begin
            sh_q    <= {`SEL_OP_READ, job_addr(job_q), 16'h0};
            nbits_q <= `SEL_FRAME_BITS;
          end
          bit_q <= 5'h0;
          tmr_q <= 32'h0;
          ph_q  <= 1'b0;
          ee_cs <= 1'b1;
          ee_di <= 1'b0;
          st_q  <= SEL_SHIFT;
        end
        SEL_SHIFT: begin
          if (tmr_q == 32'(HALF - 1)) begin
            tmr_q <= 32'h0;
            ph_q  <= ~ph_q;
            if (!ph_q) begin
              ee_di <= sh_q[24];
              ee_sk <= 1'b0;
            end else begin
              // rising edge of sk; answer is two clocks late, so half period must exceed two
              ee_sk <= 1'b1;
              sh_q  <= {sh_q[23:0], 1'b0};
              rd_q  <= {rd_q[14:0], do_q[1]};
              bit_q <= bit_q + 5'h1;
              if (bit_q + 5'h1 == nbits_q) st_q <= SEL_GAP;
            end
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        SEL_GAP: begin
          // drop cs so the device starts its internal write cycle
          ee_cs <= 1'b0;
          ee_sk <= 1'b0;
          ee_di <= 1'b0;
          tmr_q <= 32'h0;
          st_q  <= (wr_q && !ewen_q) ? SEL_WAIT : SEL_NEXT;
        end
        SEL_WAIT: begin
          // fixed wait instead of polling ready; simpler, slower writes
          if (tmr_q >= 32'(WR_BUSY_CYC)) st_q <= SEL_NEXT;
          else tmr_q <= tmr_q + 32'h1;
        end
        SEL_NEXT: begin
          if (ewen_q) begin
            ewen_q <= 1'b0;
            st_q   <= SEL_PLAN;
          end else if (job_q == last_job) begin
            st_q <= SEL_DONE;
          end else begin
            job_q <= job_q + 3'h1;
            st_q  <= SEL_PLAN;
          end
        end
        SEL_DONE: st_q <= SEL_IDLE;
        default:  st_q <= SEL_IDLE;
      endcase
    end
  end

  wire rd_done = (st_q == SEL_NEXT) && !wr_q && !ewen_q;
  wire active  = (st_q != SEL_IDLE) || boot_q;
  // a request with no eeprom fitted ends at once so polling software cannot hang
  wire finish  = (st_q == SEL_DONE) || (boot_q && settled && !present) ||
                 (!boot_q && !present && st_q == SEL_IDLE &&
                  (control_reg.fetch || control_reg.store));

  // busy view, cleared on the same edge as the triggers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)     busy <= 1'b1;
    else if (finish) busy <= 1'b0;
    else             busy <= active;
  end

  // control register: triggers read high while busy, clear when done
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      control_reg <= '{select: 1'b0, fetch: 1'b1, store: 1'b1};
    end else if (finish) begin
      control_reg.fetch <= 1'b0;
      control_reg.store <= 1'b0;
    end else if (active && st_q != SEL_IDLE) begin
      control_reg.fetch <= 1'b1;
      control_reg.store <= 1'b1;
    end else if (ctrl_we && !active) begin
      control_reg <= ctrl_wdata;
    end
  end

  // setup and address registers; eeprom loads only touch these, never control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg      <= `SEL_CFG_DFLT;
      base_reg     <= `SEL_BASE_DFLT;
      station_addr <= {3{`SEL_SA_DFLT}};
      pointer_reg  <= 6'h0;
      scratch_reg  <= 16'h0;
    end else if (rd_done) begin
      if (control_reg.select && !boot_q) scratch_reg <= rd_q;
      else unique case (job_q)
        3'h0: cfg_reg <= rd_q;
        3'h1: base_reg <= rd_q;
        3'h2: station_addr[15:0] <= rd_q;
        3'h3: station_addr[31:16] <= rd_q;
        3'h4: station_addr[47:32] <= rd_q;
        default: ;
      endcase
    end else if (reg_we && !active && !control_reg.fetch && !control_reg.store) begin
      unique case (reg_wsel)
        3'h0: cfg_reg <= reg_wdata;
        3'h1: base_reg <= reg_wdata;
        3'h2: station_addr[15:0] <= reg_wdata;
        3'h3: station_addr[31:16] <= reg_wdata;
        3'h4: station_addr[47:32] <= reg_wdata;
        3'h5: pointer_reg <= reg_wdata[5:0];
        3'h6: scratch_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  property p_busy_triggers;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_SHIFT) |=> (control_reg.fetch && control_reg.store);
  endproperty
  a_busy_triggers: assert property (p_busy_triggers) else $error("triggers low while busy");

  property p_no_serial_absent;
    @(posedge clk_sys) disable iff (sys_rst)
      (!present && st_q == SEL_IDLE && !control_reg.fetch) |=> !ee_cs;
  endproperty
  a_no_serial_absent: assert property (p_no_serial_absent) else $error("access without eeprom");

  property p_done_clears;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_DONE) |=> (!control_reg.fetch && !control_reg.store);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("triggers not cleared");

  property p_locked_regs;
    @(posedge clk_sys) disable iff (sys_rst)
      (active && !rd_done) |=> $stable(pointer_reg);
  endproperty
  a_locked_regs: assert property (p_locked_regs) else $error("register changed while busy");

  property p_sa_addr;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_PLAN && !control_reg.select && job_q == 3'h2 && !ewen_q)
        |=> (addr_q == `SEL_SA_BASE);
  endproperty
  a_sa_addr: assert property (p_sa_addr) else $error("station address word wrong");

  property p_sa_last;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_PLAN && !control_reg.select && job_q == 3'h4 && !ewen_q)
        |=> (addr_q == `SEL_SA_BASE + 6'h2);
  endproperty
  a_sa_last: assert property (p_sa_last) else $error("last station word wrong");

  property p_setup_addr;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_PLAN && !control_reg.select && job_q == 3'h1 && !ewen_q)
        |=> (addr_q == {1'b0, strap, 2'h1});
  endproperty
  a_setup_addr: assert property (p_setup_addr) else $error("base word address wrong");

  property p_ewen_first;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_IDLE && control_reg.store && !control_reg.fetch && present && !boot_q)
        |=> ewen_q;
  endproperty
  a_ewen_first: assert property (p_ewen_first) else $error("write without write-enable");

  property p_dflt_skip;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == SEL_IDLE && boot_q && settled && present && dflt) |=> (job_q == 3'h2);
  endproperty
  a_dflt_skip: assert property (p_dflt_skip) else $error("strap 7 read setup words");

endmodule : sel_loader

// File: sel_pkg.sv
package sel_pkg;
  typedef struct packed {
    logic select;
    logic fetch;
    logic store;
  } sel_ctrl_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sel_serial_t;

  typedef enum logic [6:0] {
    SEL_IDLE  = 7'b0000001,
    SEL_PLAN  = 7'b0000010,
    SEL_SHIFT = 7'b0000100,
    SEL_GAP   = 7'b0001000,
    SEL_WAIT  = 7'b0010000,
    SEL_NEXT  = 7'b0100000,
    SEL_DONE  = 7'b1000000
  } sel_state_t;
endpackage : sel_pkg

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import sel_pkg::*;
  logic        clk_sys, sys_rst, eeprom_present_pin, ctrl_we, reg_we, busy;
  logic        ee_cs, ee_sk, ee_di, ee_do;
  logic [2:0]  eeprom_offset_straps, reg_wsel;
  logic [15:0] reg_wdata, cfg_reg, base_reg, scratch_reg;
  logic [47:0] station_addr;
  logic [5:0]  pointer_reg;
  sel_ctrl_t   ctrl_wdata, control_reg;
  int          n_mismatch, n_checks, n_cs;

  // short write recovery keeps the run small
  sel_loader #(.WR_BUSY_CYC(20)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .eeprom_offset_straps(eeprom_offset_straps),
    .eeprom_present_pin(eeprom_present_pin), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .reg_we(reg_we), .reg_wsel(reg_wsel), .reg_wdata(reg_wdata), .control_reg(control_reg),
    .busy(busy), .cfg_reg(cfg_reg), .base_reg(base_reg), .station_addr(station_addr),
    .pointer_reg(pointer_reg), .scratch_reg(scratch_reg), .ee_cs(ee_cs), .ee_sk(ee_sk),
    .ee_di(ee_di), .ee_do(ee_do));

  sel_eeprom_model ee_u (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge ee_cs) n_cs++;

  function automatic logic [15:0] pat(input int i);
    return 16'ha500 | 16'(i);
  endfunction : pat

  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic [2:0] st, input logic pres);
    sys_rst              = 1'b1;
    eeprom_offset_straps = st;
    eeprom_present_pin   = pres;
    n_cs                 = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    check({control_reg.fetch, control_reg.store}, 2'h3);
    check(busy, 1'b1);
    sys_rst = 1'b0;
  endtask : do_reset

  task automatic wait_idle;
    repeat (20000) begin
      if (control_reg.fetch !== 1'b0 || control_reg.store !== 1'b0) begin
        @(posedge clk_sys);
        #1;
      end
    end
    check({control_reg.fetch, control_reg.store}, 2'h0);
    check(busy, 1'b0);
  endtask : wait_idle

  task automatic ctrl(input logic s, input logic f, input logic w);
    @(posedge clk_sys);
    #1;
    ctrl_we    = 1'b1;
    ctrl_wdata = '{s, f, w};
    @(posedge clk_sys);
    #1;
    ctrl_we = 1'b0;
  endtask : ctrl

  task automatic wreg(input logic [2:0] sel, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_we    = 1'b1;
    reg_wsel  = sel;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_we = 1'b0;
  endtask : wreg

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    test_done;
  end

  initial begin
    {ctrl_we, reg_we, reg_wsel, reg_wdata, ctrl_wdata} = '0;
    for (int i = 0; i < 64; i++) ee_u.mem[i] = pat(i);
    do_reset(3'h1, 1'b1);
    wait_idle;
    check(cfg_reg, pat(4));
    check(base_reg, pat(5));
    check(station_addr, {pat(34), pat(33), pat(32)});
    // scratch write to the top word, with a locked write attempted meanwhile
    wreg(3'h5, 16'h003f);
    check(pointer_reg, 6'h3f);
    wreg(3'h6, 16'h5a3c);
    ctrl(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    check({control_reg.fetch, control_reg.store}, 2'h3);
    check(busy, 1'b1);
    wreg(3'h0, 16'hdead);
    wait_idle;
    check(ee_u.mem[63], 16'h5a3c);
    check(cfg_reg, pat(4));
    wreg(3'h6, 16'h0000);
    ctrl(1'b1, 1'b1, 1'b0);
    wait_idle;
    check(scratch_reg, 16'h5a3c);
    check(control_reg, 3'h4);
    // normal store, then reload into cleared registers
    ctrl(1'b0, 1'b0, 1'b0);
    wreg(3'h0, 16'h1234);
    wreg(3'h1, 16'h4321);
    ctrl(1'b0, 1'b0, 1'b1);
    wait_idle;
    check(ee_u.mem[4], 16'h1234);
    check(ee_u.mem[5], 16'h4321);
    wreg(3'h0, 16'h0000);
    wreg(3'h1, 16'h0000);
    wreg(3'h2, 16'h0000);
    ctrl(1'b0, 1'b1, 1'b0);
    wait_idle;
    check({cfg_reg, base_reg}, {16'h1234, 16'h4321});
    check(station_addr, {pat(34), pat(33), pat(32)});
    // strap 7: only the station address comes from the eeprom
    do_reset(3'h7, 1'b1);
    wait_idle;
    check({cfg_reg, base_reg}, 32'h00000000);
    check(station_addr, {pat(34), pat(33), pat(32)});
    // strap 7 after a store: a later fetch still skips the setup words
    wreg(3'h0, 16'h1111);
    ctrl(1'b0, 1'b0, 1'b1);
    wait_idle;
    check(ee_u.mem[28], 16'h1111);
    wreg(3'h0, 16'h0000);
    wreg(3'h2, 16'h0000);
    ctrl(1'b0, 1'b1, 1'b0);
    wait_idle;
    check(cfg_reg, 16'h0000);
    check(station_addr, {pat(34), pat(33), pat(32)});
    // no eeprom fitted: no frames at all, defaults kept, requests end at once
    do_reset(3'h1, 1'b0);
    wait_idle;
    ctrl(1'b0, 1'b1, 1'b0);
    wait_idle;
    repeat (200) @(posedge clk_sys);
    check(n_cs, 0);
    check({cfg_reg, base_reg}, 32'h00000000);
    check(station_addr, 48'h000000000000);
    test_done;
  end
endmodule : testbench
